// [design/serial_dac_word_loader_params.svh]
// constants for the serial converter word loader
`ifndef SERIAL_DAC_WORD_LOADER_PARAMS_SVH
`define SERIAL_DAC_WORD_LOADER_PARAMS_SVH
`define FRAME_LEN_14        16
`define FRAME_LEN_16        24
`define UPDATE_EDGE_14      16
`define UPDATE_EDGE_16      18
`define CODE_RESET_VALUE    16'h0000
`define MODE_RESET_VALUE    2'h0
`define WAKE_TIME_US        50
`define CLK_SYS_MHZ         100
`define WAKE_CYCLES         (`WAKE_TIME_US * `CLK_SYS_MHZ)
`define EDGE_CNT_W          5
`define WAKE_CNT_W          16
`endif

// [design/serial_dac_word_loader_pkg.sv]
// types for the serial converter word loader
package serial_dac_word_loader_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_PD_1K   = 2'h1,
        MODE_PD_100K = 2'h2,
        MODE_PD_HIZ  = 2'h3
    } power_mode_t;

    typedef struct packed {
        logic        amp_enable;
        logic        pulldown_1k;
        logic        pulldown_100k;
        logic        output_ready;
    } out_stage_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SHIFT = 2'h1,
        ST_DONE  = 2'h3
    } frame_state_t;
endpackage : serial_dac_word_loader_pkg

// [design/serial_dac_word_loader.sv]
// serial front end: frame shifter, code/mode loader, output stage selects
`timescale 1ns/100ps
`default_nettype none
`include "serial_dac_word_loader_params.svh"

// What this block does
// R1: frame select falling edge arms shifter
// R2: 14-bit variant shifts 16 bits, falling edges
// R3: 16-bit variant shifts 24 bits, falling edges
// R4: first two bits are power mode
// R5: 14-bit variant applies on 16th edge
// R6: 16-bit variant applies on 18th edge
// R7: six trailing bits ignored in 16-bit variant
// R8: host holds select high 20ns between frames
// R9: after update, wait for select rise and fall
// R10: host may raise select after 18th bit
// R11: 14-bit early rise clears shifter, discards
// R12: 16-bit early rise clears shifter, discards
// R13: aborted frame keeps code and mode
// R14: reset loads zero code until valid frame
// R15: mode 00 is normal, amplifier drives
// R16: 01 1k, 10 100k, 11 high-z, amp off
// R17: power-down keeps stored code
// R18: allow 50us wake-up before output valid
// R19: code is straight binary 14 or 16 bits
// R20: 14-bit host keeps select low 16 edges
// R21: 16-bit host keeps select low 24 edges
// R22: host sends most significant bit first
// R23: layout mode high, mode low, code, pad
// R24: variant is build-time parameter
module serial_dac_word_loader
    import serial_dac_word_loader_pkg::*;
#(
    parameter bit WIDE_VARIANT = 1'b1   // [R24]
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        sclk,
    input  wire logic        frame_sel_n,
    input  wire logic        sdata,
    output logic [15:0]      dac_code,
    output power_mode_t      power_mode,
    output out_stage_t       out_stage
);

    localparam int FRAME_LEN  = WIDE_VARIANT ? `FRAME_LEN_16
                                             : `FRAME_LEN_14;
    localparam int UPDATE_AT  = WIDE_VARIANT ? `UPDATE_EDGE_16
                                             : `UPDATE_EDGE_14;
    localparam int CODE_W     = UPDATE_AT - 2;
    localparam int WAKE_COUNT = `WAKE_CYCLES;

    ////////////////////////////////////////////////////////////////////
    // helpers shared by the link and the system side

    // the update edge is the last edge of the meaningful bits
    function automatic logic is_update_edge(
        input frame_state_t           st,
        input logic [`EDGE_CNT_W-1:0] cnt
    );
        return (st == ST_SHIFT) &&
               (cnt == `EDGE_CNT_W'(UPDATE_AT - 1));
    endfunction : is_update_edge

    // mode pair sits above the code bits, high bit first
    function automatic power_mode_t mode_of_word(
        input logic [CODE_W+1:0] w
    );
        return power_mode_t'(w[CODE_W+1:CODE_W]);
    endfunction : mode_of_word

    // narrow variant pads the top code bits with zeros
    function automatic logic [15:0] code_of_word(
        input logic [CODE_W+1:0] w
    );
        return 16'(w[CODE_W-1:0]);
    endfunction : code_of_word

    // edge count held at its top so a long frame cannot wrap it
    function automatic logic [`EDGE_CNT_W-1:0] count_up(
        input logic [`EDGE_CNT_W-1:0] cnt
    );
        if (cnt == '1) begin
            return cnt;
        end
        return cnt + `EDGE_CNT_W'(1);
    endfunction : count_up

    // one select per pull-down mode, none for high-z; only normal mode drives the amplifier
    function automatic out_stage_t stage_of_mode(
        input power_mode_t m,
        input logic        woke
    );
        out_stage_t s;
        s = '0;
        case (m)
            MODE_NORMAL: begin
                s.amp_enable   = 1'b1;
                s.output_ready = woke;
            end
            MODE_PD_1K: begin
                s.pulldown_1k = 1'b1;
            end
            MODE_PD_100K: begin
                s.pulldown_100k = 1'b1;
            end
            MODE_PD_HIZ: begin
                // output left floating, nothing enabled
                s = '0;
            end
            default: begin
                s = '0;
            end
        endcase
        return s;
    endfunction : stage_of_mode

    ////////////////////////////////////////////////////////////////////
    // link side: runs on the falling serial clock
    // the select rise is sampled on sclk, so an abort is only seen at
    // the next falling edge; with select high no update can fire anyway

    frame_state_t              state_q;
    logic [`EDGE_CNT_W-1:0]    edge_cnt_q;
    logic [FRAME_LEN-1:0]      shift_q;
    logic                      sel_seen_high_q;
    logic [CODE_W+1:0]         word_q;
    logic                      word_tgl_q;
    logic                      link_rst_m_q;
    logic                      link_rst_q;
    logic [FRAME_LEN-1:0]      shift_d;

    // reset carried into link domain
    always_ff @(negedge sclk) begin
        link_rst_m_q <= srst;
        link_rst_q   <= link_rst_m_q;
    end

    assign shift_d = {shift_q[FRAME_LEN-2:0], sdata};   // [R22]

    ////////////////////////////////////////////////////////////////////
    // link side frame control, one process per register, word and toggle sharing one

    // idle until a fresh low, shift to the update edge, then done
    always_ff @(negedge sclk) begin
        if (link_rst_q || frame_sel_n) begin
            // early rise drops the frame  [R11] [R12] [R13]
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (sel_seen_high_q) begin
                        state_q <= ST_SHIFT;              // [R1] [R9]
                    end
                end
                ST_SHIFT: begin
                    if (is_update_edge(state_q, edge_cnt_q)) begin
                        state_q <= ST_DONE;               // [R5] [R6]
                    end
                end
                ST_DONE: begin
                    // stays here until select is seen high  [R9]
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // edges counted from the first bit of a frame
    always_ff @(negedge sclk) begin
        if (link_rst_q || frame_sel_n) begin
            edge_cnt_q <= '0;
        end else if (state_q == ST_IDLE) begin
            if (sel_seen_high_q) begin
                edge_cnt_q <= `EDGE_CNT_W'(1);
            end
        end else if (state_q == ST_SHIFT) begin
            edge_cnt_q <= count_up(edge_cnt_q);
        end
    end

    // shifter cleared by an early rise; trailing bits shift in but never reach the word
    always_ff @(negedge sclk) begin
        if (link_rst_q || frame_sel_n) begin
            shift_q <= '0;                                // [R11] [R12]
        end else if (state_q == ST_IDLE) begin
            if (sel_seen_high_q) begin
                shift_q <= shift_d;                       // [R2] [R3]
            end
        end else begin
            shift_q <= shift_d;                           // [R2] [R3] [R7]
        end
    end

    // a new frame needs select seen high at a falling edge first
    always_ff @(negedge sclk) begin
        if (link_rst_q || frame_sel_n) begin
            sel_seen_high_q <= 1'b1;
        end else begin
            sel_seen_high_q <= 1'b0;                      // [R9]
        end
    end

    // capture word on the update edge and flag it by toggle
    // word_q then stays still until the next update, long after the
    // system side has taken it
    always_ff @(negedge sclk) begin
        if (link_rst_q) begin
            word_q     <= '0;
            word_tgl_q <= 1'b0;
        end else if (!frame_sel_n &&
                     is_update_edge(state_q, edge_cnt_q)) begin
            word_q     <= shift_d[CODE_W+1:0];            // [R5] [R6] [R23]
            word_tgl_q <= ~word_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // system side: toggle crossing, word stable while toggle settles

    logic                      tgl_m_q;
    logic                      tgl_s_q;
    logic                      tgl_p_q;
    logic [15:0]               code_q;
    logic [15:0]               code_d;
    power_mode_t               mode_q;
    power_mode_t               mode_d;
    logic [`WAKE_CNT_W-1:0]    wake_q;
    logic [`WAKE_CNT_W-1:0]    wake_d;
    logic                      load_evt;
    logic                      wake_start;
    out_stage_t                stage_d;

    // two flops before anything reads the toggle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tgl_m_q <= 1'b0;
            tgl_s_q <= 1'b0;
        end else begin
            tgl_m_q <= word_tgl_q;
            tgl_s_q <= tgl_m_q;
        end
    end

    // last settled toggle, for the change detect
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tgl_p_q <= 1'b0;
        end else begin
            tgl_p_q <= tgl_s_q;
        end
    end

    assign load_evt = tgl_s_q ^ tgl_p_q;

    // a load takes the captured word; otherwise both hold
    // the word is read only here, once the toggle has settled
    always_comb begin
        code_d = code_q;
        mode_d = mode_q;
        if (load_evt) begin
            code_d = code_of_word(word_q);                // [R19]
            mode_d = mode_of_word(word_q);                // [R4]
        end
    end

    // code register: zero from reset until a frame reaches its update edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            code_q <= `CODE_RESET_VALUE;                  // [R14]
        end else begin
            code_q <= code_d;
        end
    end

    // mode pair loads with the code, never on its own
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_q <= power_mode_t'(`MODE_RESET_VALUE);
        end else begin
            mode_q <= mode_d;                             // [R4]
        end
    end

    // a load that brings the mode from power-down back to normal
    assign wake_start = load_evt && (mode_q != MODE_NORMAL) &&
                        (mode_d == MODE_NORMAL);

    // wake timer counts down to zero; ready is held low meanwhile
    // fixed length, so a slower analog recovery is not covered
    always_comb begin
        wake_d = wake_q;
        if (wake_start) begin
            wake_d = `WAKE_CNT_W'(WAKE_COUNT);            // [R18]
        end else if (wake_q != '0) begin
            wake_d = wake_q - `WAKE_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wake_q <= '0;
        end else begin
            wake_q <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs; power-down never touches the code  [R17]

    // stage selects follow the registered mode
    always_comb begin
        stage_d = stage_of_mode(mode_q, (wake_q == '0)); // [R15] [R16] [R18]
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dac_code <= `CODE_RESET_VALUE;
        end else begin
            dac_code <= code_q;                           // [R17]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            power_mode <= MODE_NORMAL;
        end else begin
            power_mode <= mode_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_stage <= '0;
        end else begin
            out_stage <= stage_d;
        end
    end

endmodule : serial_dac_word_loader
`default_nettype wire

// [dv/loader_properties.sv]
// port assertions for the serial word loader
`timescale 1ns/100ps
`default_nettype none
module loader_properties
    import serial_dac_word_loader_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        sclk,
    input wire logic [15:0] dac_code,
    input wire power_mode_t power_mode,
    input wire out_stage_t  out_stage
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic       sclk_q;
    logic [3:0] quiet_q;
    // cycles since the serial clock last moved, saturating
    always_ff @(posedge clk_sys) begin
        sclk_q <= sclk;
        if (srst || sclk != sclk_q) quiet_q <= 4'h0;
        else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
    sequence s_wake;
        $past(power_mode) != MODE_NORMAL && power_mode == MODE_NORMAL;
    endsequence
    sequence s_dark;
        !out_stage.output_ready [*8];
    endsequence
    AST_WAKE: assert property (s_wake |-> s_dark)
        else $error("ready too soon after wake");
    AST_DARK: assert property ((power_mode != MODE_NORMAL) [*3]
        |-> !out_stage.output_ready) else $error("ready in power-down");
    AST_HIZ: assert property ((power_mode == MODE_PD_HIZ) [*3]
        |-> out_stage == 4'h0) else $error("high-z stage wrong");
    AST_PD1K: assert property ((power_mode == MODE_PD_1K) [*3]
        |-> out_stage == 4'h4) else $error("1k stage wrong");
    AST_PD100K: assert property ((power_mode == MODE_PD_100K) [*3]
        |-> out_stage == 4'h2) else $error("100k stage wrong");
    AST_NORMAL: assert property ((power_mode == MODE_NORMAL) [*3]
        |-> out_stage[3:1] == 3'h4) else $error("normal stage wrong");
    AST_CODE_QUIET: assert property ($changed(dac_code)
        |-> quiet_q < 4'h8) else $error("code moved with no frame");
    AST_MODE_QUIET: assert property ($changed(power_mode)
        |-> quiet_q < 4'h8) else $error("mode moved with no frame");
endmodule : loader_properties
`default_nettype wire

// [dv/host_model.sv]
// host side serial master for the word loader
`timescale 1ns/100ps
`default_nettype none
module host_model (
    output logic sclk,
    output logic frame_sel_n,
    output logic sdata
);
    // serial clock idles high and runs only when asked
    initial begin
        sclk = 1'b1;
        frame_sel_n = 1'b1;
        sdata = 1'b0;
    end
    task edges(input int n);
        repeat (n) begin
            #6 sclk = 1'b0;
            #6 sclk = 1'b1;
        end
    endtask : edges
    // word left aligned, msb first; hold keeps select low afterwards
    task send(input logic [23:0] w, input int n, input bit hold);
        frame_sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdata = w[23-i];
            edges(1);
        end
        sdata = ~sdata;
        if (!hold) begin
            frame_sel_n = 1'b1;
            edges(2);
        end
    endtask : send
endmodule : host_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the serial word loader
`timescale 1ns/100ps
`default_nettype none
`include "serial_dac_word_loader_params.svh"
module testbench;
    import serial_dac_word_loader_pkg::*;
    logic        clk_sys;
    logic        srst;
    wire logic   sclk, frame_sel_n, sdata;
    logic [15:0] dac_code;
    power_mode_t power_mode;
    out_stage_t  out_stage;
    int          num_errors, n_compared;
    serial_dac_word_loader dut (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
        .frame_sel_n(frame_sel_n), .sdata(sdata), .dac_code(dac_code),
        .power_mode(power_mode), .out_stage(out_stage));
    host_model host (.sclk(sclk), .frame_sel_n(frame_sel_n), .sdata(sdata));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task conclude;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // crossing takes a few cycles, so look well after the frame
    task look(input logic [15:0] c, input logic [1:0] m);
        repeat (8) @(posedge clk_sys);
        chk(dac_code, c);
        chk(power_mode, m);
    endtask : look
    task t_full;
        host.send({2'h0, 16'hA5C3, 6'h3F}, 24, 0);
        look(16'hA5C3, 2'h0);
    endtask : t_full
    task t_short;
        host.send({2'h0, 16'h1234, 6'h00}, 18, 0);
        look(16'h1234, 2'h0);
        host.send({2'h1, 16'hFFFF, 6'h00}, 17, 0);
        look(16'h1234, 2'h0);
    endtask : t_short
    task t_hold;
        host.send({2'h0, 16'h0F0F, 6'h00}, 24, 1);
        host.send({2'h3, 16'hBEEF, 6'h00}, 24, 0);
        look(16'h0F0F, 2'h0);
    endtask : t_hold
    task t_modes;
        for (int m = 1; m < 4; m++) begin
            host.send({m[1:0], 16'h0F0F, 6'h00}, 18, 0);
            look(16'h0F0F, m[1:0]);
        end
        host.send({2'h0, 16'h0F0F, 6'h00}, 18, 0);
        look(16'h0F0F, 2'h0);
        chk(out_stage.output_ready, 1'b0);
        repeat (`WAKE_CYCLES) @(posedge clk_sys);
        chk(out_stage.output_ready, 1'b1);
    endtask : t_modes
    initial begin
        num_errors = 0;
        n_compared = 0;
        srst = 1'b1;
        // link reset needs serial clock edges while held
        #3 host.edges(3);
        @(posedge clk_sys);
        #1 srst = 1'b0;
        host.edges(2);
        look(16'h0000, 2'h0);
        chk(out_stage, 4'h9);
        t_full;
        t_short;
        t_hold;
        t_modes;
        conclude;
    end
    initial begin
        #200000 num_errors++;
        conclude;
    end
endmodule : testbench
bind serial_dac_word_loader loader_properties props (.clk_sys(clk_sys),
    .srst(srst), .sclk(sclk), .dac_code(dac_code),
    .power_mode(power_mode), .out_stage(out_stage));
`default_nettype wire
